/* bccs_config_space.sv */
// Contract
// - The subsystem identification header byte reads the constant 0Dh in bits 7:0.
// - Its link pointer reads B0h by default and A0h while slot identification is enabled.
// - A read-only 16-bit card maker ident sits in bits 15:0 and card ident in bits 31:16.
// - The express capability header byte reads the constant 10h.
// - The express capability link pointer reads D8h.
// - Port type in bits 23:20 reads 7h as forward bridge and 8h as reverse bridge.
// - Slot implemented bit 24 reads 0 forward and 1 reverse.
// - Phantom function field bits 4:3 reads 00.
// - Bit 5 of the device capability word reads 1 for 8-bit tags.
// - The L0s acceptable latency field bits 8:6 reads 000.
// - The L1 acceptable latency field bits 11:9 reads 000.
// - Attention button bit 12 reads 1 only with strapped hot-plug in forward mode.
// - Attention and power indicator bits 13 and 14 read 1 with strapped hot-plug forward.
// - Power limit value bits 25:18 load from each power limit message and reset to zero.
// - Power limit scale bits 27:26 load from the same message and reset to zero.
`timescale 1ns/10ps
module bccs_config_space
  import bccs_pkg::*;
#(
  parameter logic [15:0] CARD_MAKER_IDENT = BCCS_CARD_MAKER_DEF,
  parameter logic [15:0] CARD_IDENT       = BCCS_CARD_IDENT_DEF
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // axi4-lite slave
  input  wire logic [BCCS_ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [BCCS_DATA_W-1:0]      s_axi_wdata,
  input  wire logic [BCCS_STRB_W-1:0]      s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [BCCS_ADDR_W-1:0]      s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [BCCS_DATA_W-1:0]           s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // bridge side
  input  wire logic                        reverse_bridge_strap,
  input  wire logic                        hotplug_strap,
  input  wire logic                        slot_ident_enable,
  input  wire logic                        power_limit_msg,
  input  wire logic [BCCS_PWR_VALUE_W-1:0] power_limit_value,
  input  wire logic [BCCS_PWR_SCALE_W-1:0] power_limit_scale,
  output logic [BCCS_PWR_VALUE_W-1:0]      captured_power_value,
  output logic [BCCS_PWR_SCALE_W-1:0]      captured_power_scale,
  output logic                             reverse_mode
);

  // ****************************************
  // strap capture
  // ****************************************
  logic strap_reverse;
  logic strap_hotplug;

  // straps follow the pins while reset is held and freeze at release,
  // so a pin that moves later cannot change the reported personality
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_reverse <= reverse_bridge_strap;
      strap_hotplug <= hotplug_strap;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reverse_mode <= 1'b0;
    end else begin
      reverse_mode <= strap_reverse;
    end
  end

  // ****************************************
  // slot power limit capture
  // ****************************************
  logic [BCCS_PWR_VALUE_W-1:0] pwr_value;
  logic [BCCS_PWR_SCALE_W-1:0] pwr_scale;

  bccs_capture_reg #(
    .WIDTH     (BCCS_PWR_VALUE_W),
    .RST_VALUE (BCCS_PWR_VALUE_RST)
  ) u_pwr_value (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (power_limit_msg),
    .din     (power_limit_value),
    .q       (pwr_value)
  );

  bccs_capture_reg #(
    .WIDTH     (BCCS_PWR_SCALE_W),
    .RST_VALUE (BCCS_PWR_SCALE_RST)
  ) u_pwr_scale (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (power_limit_msg),
    .din     (power_limit_scale),
    .q       (pwr_scale)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      captured_power_value <= BCCS_PWR_VALUE_RST;
      captured_power_scale <= BCCS_PWR_SCALE_RST;
    end else begin
      captured_power_value <= pwr_value;
      captured_power_scale <= pwr_scale;
    end
  end

  // ****************************************
  // field assembly
  // ****************************************
  wire logic       hotplug_fwd;
  wire logic [7:0] subsys_next;
  wire logic [3:0] port_type;
  wire logic       slot_impl;
  wire logic       attn_button;
  wire logic       attn_indicator;
  wire logic       power_indicator;

  assign subsys_next     = slot_ident_enable ? BCCS_NEXT_TO_SLOT_ID
                                             : BCCS_NEXT_TO_EXPRESS;
  assign port_type       = strap_reverse ? BCCS_PORT_REV : BCCS_PORT_FWD;
  assign slot_impl       = strap_reverse;
  // hot-plug is a forward-bridge feature; a reverse bridge reports none
  assign hotplug_fwd     = strap_hotplug & ~strap_reverse;
  assign attn_button     = hotplug_fwd;
  assign attn_indicator  = hotplug_fwd;
  assign power_indicator = hotplug_fwd;

  wire logic [BCCS_DATA_W-1:0] word_subsys_hdr;
  wire logic [BCCS_DATA_W-1:0] word_card_ident;
  wire logic [BCCS_DATA_W-1:0] word_express_hdr;
  wire logic [BCCS_DATA_W-1:0] word_devcap;

  assign word_subsys_hdr  = {BCCS_SUBSYS_RSVD,
                             subsys_next,
                             BCCS_SUBSYS_CAP_ID};
  assign word_card_ident  = {CARD_IDENT, CARD_MAKER_IDENT};
  assign word_express_hdr = {BCCS_EXPRESS_RSVD,
                             BCCS_INT_MSG_NUM,
                             slot_impl,
                             port_type,
                             BCCS_CAP_VERSION,
                             BCCS_NEXT_TO_VPD,
                             BCCS_EXPRESS_CAP_ID};
  assign word_devcap      = {BCCS_DEVCAP_RSVD_HI,
                             pwr_scale,
                             pwr_value,
                             BCCS_DEVCAP_RSVD_LO,
                             power_indicator,
                             attn_indicator,
                             attn_button,
                             BCCS_L1_LATENCY,
                             BCCS_L0S_LATENCY,
                             BCCS_TAG_8BIT,
                             BCCS_PHANTOM_FUNCS,
                             BCCS_MAX_PAYLOAD};

  // ****************************************
  // address decode
  // ****************************************
  wire logic                   rd_hit_subsys;
  wire logic                   rd_hit_card;
  wire logic                   rd_hit_express;
  wire logic                   rd_hit_devcap;
  wire logic                   rd_hit;
  wire logic [BCCS_DATA_W-1:0] rd_word;
  wire logic [1:0]             rd_resp;

  assign rd_hit_subsys  = (s_axi_araddr == BCCS_OFS_SUBSYS_HDR);
  assign rd_hit_card    = (s_axi_araddr == BCCS_OFS_CARD_IDENT);
  assign rd_hit_express = (s_axi_araddr == BCCS_OFS_EXPRESS_HDR);
  assign rd_hit_devcap  = (s_axi_araddr == BCCS_OFS_DEVCAP);
  assign rd_hit         = rd_hit_subsys | rd_hit_card | rd_hit_express | rd_hit_devcap;

  // one-hot and-or select; an unmapped address reads zero
  assign rd_word = ({BCCS_DATA_W{rd_hit_subsys}}  & word_subsys_hdr)
                 | ({BCCS_DATA_W{rd_hit_card}}    & word_card_ident)
                 | ({BCCS_DATA_W{rd_hit_express}} & word_express_hdr)
                 | ({BCCS_DATA_W{rd_hit_devcap}}  & word_devcap);
  assign rd_resp = rd_hit ? BCCS_RESP_OKAY : BCCS_RESP_SLVERR;

  logic [BCCS_ADDR_W-1:0] wr_addr;
  wire logic              wr_hit;
  wire logic [1:0]        wr_resp;

  assign wr_hit  = (wr_addr == BCCS_OFS_SUBSYS_HDR)
                 | (wr_addr == BCCS_OFS_CARD_IDENT)
                 | (wr_addr == BCCS_OFS_EXPRESS_HDR)
                 | (wr_addr == BCCS_OFS_DEVCAP);
  // mapped writes complete cleanly but store nothing
  assign wr_resp = wr_hit ? BCCS_RESP_OKAY : BCCS_RESP_SLVERR;

  // ****************************************
  // write channel
  // ****************************************
  bccs_wr_state_t wr_state;
  bccs_wr_state_t next_wr_state;
  logic           aw_held;
  logic           w_held;

  wire logic aw_take;
  wire logic w_take;
  wire logic b_take;
  wire logic aw_have;
  wire logic w_have;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign b_take  = s_axi_bvalid & s_axi_bready;
  assign aw_have = aw_held | aw_take;
  assign w_have  = w_held | w_take;

  always_comb begin
    next_wr_state = wr_state;
    case (wr_state)
      BCCS_WR_COLLECT: begin
        if (aw_held & w_held) begin
          next_wr_state = BCCS_WR_ANSWER;
        end
      end
      BCCS_WR_ANSWER: begin
        if (b_take) begin
          next_wr_state = BCCS_WR_COLLECT;
        end
      end
      default: begin
        next_wr_state = BCCS_WR_COLLECT;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_state <= BCCS_WR_COLLECT;
    end else begin
      wr_state <= next_wr_state;
    end
  end

  // address and data are held independently, in either order
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else if (b_take) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      aw_held <= aw_have;
      w_held  <= w_have;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_addr <= '0;
    end else if (aw_take) begin
      wr_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (b_take) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      s_axi_awready <= ~aw_have & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have & ~s_axi_bvalid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= BCCS_RESP_OKAY;
    end else if (wr_state == BCCS_WR_COLLECT && aw_held && w_held) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_resp;
    end else if (b_take) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  bccs_rd_state_t rd_state;
  bccs_rd_state_t next_rd_state;

  wire logic ar_take;
  wire logic r_take;

  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign r_take  = s_axi_rvalid & s_axi_rready;

  always_comb begin
    next_rd_state = rd_state;
    case (rd_state)
      BCCS_RD_WAIT: begin
        if (ar_take) begin
          next_rd_state = BCCS_RD_ANSWER;
        end
      end
      BCCS_RD_ANSWER: begin
        if (r_take) begin
          next_rd_state = BCCS_RD_WAIT;
        end
      end
      default: begin
        next_rd_state = BCCS_RD_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_state <= BCCS_RD_WAIT;
    end else begin
      rd_state <= next_rd_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= (next_rd_state == BCCS_RD_WAIT);
    end
  end

  // the word is frozen at the address handshake so a power limit
  // message during the data phase cannot tear the answer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= BCCS_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_resp;
    end else if (r_take) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // bccs_config_space

/* bccs_pkg.sv */
package bccs_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int          BCCS_ADDR_W          = 8;
  localparam int          BCCS_DATA_W          = 32;
  localparam int          BCCS_STRB_W          = 4;
  localparam logic [1:0]  BCCS_RESP_OKAY       = 2'h0;
  localparam logic [1:0]  BCCS_RESP_SLVERR     = 2'h2;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0]  BCCS_OFS_SUBSYS_HDR  = 8'hA8;
  localparam logic [7:0]  BCCS_OFS_CARD_IDENT  = 8'hAC;
  localparam logic [7:0]  BCCS_OFS_EXPRESS_HDR = 8'hB0;
  localparam logic [7:0]  BCCS_OFS_DEVCAP      = 8'hB4;

  // ****************************************
  // subsystem identification header
  // ****************************************
  localparam logic [7:0]  BCCS_SUBSYS_CAP_ID   = 8'h0D;
  localparam logic [7:0]  BCCS_NEXT_TO_EXPRESS = 8'hB0;
  localparam logic [7:0]  BCCS_NEXT_TO_SLOT_ID = 8'hA0;
  localparam logic [15:0] BCCS_SUBSYS_RSVD     = 16'h0000;

  // ****************************************
  // express capability header
  // ****************************************
  localparam logic [7:0]  BCCS_EXPRESS_CAP_ID  = 8'h10;
  localparam logic [7:0]  BCCS_NEXT_TO_VPD     = 8'hD8;
  localparam logic [3:0]  BCCS_CAP_VERSION     = 4'h1;
  localparam logic [3:0]  BCCS_PORT_FWD        = 4'h7;
  localparam logic [3:0]  BCCS_PORT_REV        = 4'h8;
  localparam logic [4:0]  BCCS_INT_MSG_NUM     = 5'h00;
  localparam logic [1:0]  BCCS_EXPRESS_RSVD    = 2'h0;

  // ****************************************
  // device capability fields
  // ****************************************
  localparam logic [2:0]  BCCS_MAX_PAYLOAD     = 3'h1;
  localparam logic [1:0]  BCCS_PHANTOM_FUNCS   = 2'h0;
  localparam logic        BCCS_TAG_8BIT        = 1'b1;
  localparam logic [2:0]  BCCS_L0S_LATENCY     = 3'h0;
  localparam logic [2:0]  BCCS_L1_LATENCY      = 3'h0;
  localparam logic [2:0]  BCCS_DEVCAP_RSVD_LO  = 3'h0;
  localparam logic [3:0]  BCCS_DEVCAP_RSVD_HI  = 4'h0;
  localparam int          BCCS_PWR_VALUE_W     = 8;
  localparam int          BCCS_PWR_SCALE_W     = 2;
  localparam logic [7:0]  BCCS_PWR_VALUE_RST   = 8'h00;
  localparam logic [1:0]  BCCS_PWR_SCALE_RST   = 2'h0;

  // arbitrary neutral identity values
  localparam logic [15:0] BCCS_CARD_MAKER_DEF  = 16'h5A5A;
  localparam logic [15:0] BCCS_CARD_IDENT_DEF  = 16'hA5A5;

  typedef enum logic {BCCS_WR_COLLECT, BCCS_WR_ANSWER} bccs_wr_state_t;
  typedef enum logic {BCCS_RD_WAIT, BCCS_RD_ANSWER} bccs_rd_state_t;

endpackage

/* bccs_capture_reg.sv */
`timescale 1ns/10ps
module bccs_capture_reg #(
  parameter int            WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] q
);

  // every new message overwrites the previous capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= RST_VALUE;
    end else if (load) begin
      q <= din;
    end
  end

endmodule // bccs_capture_reg

/* bccs_config_space_checker.sv */
`timescale 1ns/10ps
module bccs_config_space_checker
  import bccs_pkg::*;
#(
  parameter logic [15:0] CARD_MAKER_IDENT = BCCS_CARD_MAKER_DEF,
  parameter logic [15:0] CARD_IDENT       = BCCS_CARD_IDENT_DEF
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        hotplug_strap,
  input wire logic        slot_ident_enable,
  input wire logic        power_limit_msg,
  input wire logic [7:0]  power_limit_value,
  input wire logic [1:0]  power_limit_scale,
  input wire logic [7:0]  captured_power_value,
  input wire logic [1:0]  captured_power_scale,
  input wire logic        reverse_mode
);
  // ********************
  // read tracking
  // ********************
  logic [7:0] rd_addr;
  logic       rd_sie;
  logic       hp_q;
  logic [9:0] pwr_q;
  logic [9:0] rd_pwr;
  wire        take = s_axi_arvalid && s_axi_arready;
  wire [31:0] d    = s_axi_rdata;
  wire        v_a8 = s_axi_rvalid && rd_addr == BCCS_OFS_SUBSYS_HDR;
  wire        v_ac = s_axi_rvalid && rd_addr == BCCS_OFS_CARD_IDENT;
  wire        v_b0 = s_axi_rvalid && rd_addr == BCCS_OFS_EXPRESS_HDR;
  wire        v_b4 = s_axi_rvalid && rd_addr == BCCS_OFS_DEVCAP;
  wire        v_no = s_axi_rvalid && !(v_a8 || v_ac || v_b0 || v_b4);

  // read data is frozen when the address is taken, so inputs are sampled there too
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hp_q  <= hotplug_strap;
      pwr_q <= '0;
    end else if (power_limit_msg) begin
      pwr_q <= {power_limit_scale, power_limit_value};
    end
    if (take) begin
      rd_addr <= s_axi_araddr;
      rd_sie  <= slot_ident_enable;
      rd_pwr  <= pwr_q;
    end
  end

  // ********************
  // properties
  // ********************
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);

  subsys_hdr_a: assert property (v_a8 |-> d[7:0] == 8'h0D && d[31:16] == 16'h0000)
    else $error("subsystem header word wrong");
  next_link_a: assert property (v_a8 |-> d[15:8] == (rd_sie ? 8'hA0 : 8'hB0))
    else $error("subsystem next link wrong");
  card_ident_a: assert property (v_ac |-> d == {CARD_IDENT, CARD_MAKER_IDENT})
    else $error("card ident word wrong");
  express_hdr_a: assert property (v_b0 |-> d[15:0] == 16'hD810)
    else $error("express header wrong");
  port_type_a: assert property (v_b0 |-> d[24:20] == (reverse_mode ? 5'h18 : 5'h07))
    else $error("port type or slot bit wrong");
  devcap_fixed_a: assert property (v_b4 |->
    d[11:3] == 9'h004 && d[17:15] == 3'h0)
    else $error("fixed device capability fields wrong");
  hotplug_bits_a: assert property (v_b4 |-> d[14:12] == {3{hp_q && !reverse_mode}})
    else $error("hot-plug presence bits wrong");
  power_field_a: assert property (v_b4 |-> d[27:18] == rd_pwr && d[31:28] == 4'h0)
    else $error("power limit field wrong");
  power_copy_a: assert property (power_limit_msg |-> ##2
    {captured_power_scale, captured_power_value} == $past({power_limit_scale, power_limit_value}, 2))
    else $error("captured power outputs wrong");
  unmapped_rd_a: assert property (v_no |->
    d == 32'h0000_0000 && s_axi_rresp == BCCS_RESP_SLVERR)
    else $error("unmapped read answer wrong");
  rd_answer_a: assert property (take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule // bccs_config_space_checker

bind bccs_config_space bccs_config_space_checker #(
  .CARD_MAKER_IDENT(CARD_MAKER_IDENT), .CARD_IDENT(CARD_IDENT)
) u_chk (
  .clk_sys(clk_sys), .rst(rst), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .hotplug_strap(hotplug_strap),
  .slot_ident_enable(slot_ident_enable), .power_limit_msg(power_limit_msg),
  .power_limit_value(power_limit_value), .power_limit_scale(power_limit_scale),
  .captured_power_value(captured_power_value), .captured_power_scale(captured_power_scale),
  .reverse_mode(reverse_mode)
);

/* bccs_config_space_tb.sv */
`timescale 1ns/10ps
module bccs_config_space_tb;
  import bccs_pkg::*;
  logic        clk_sys = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        reverse_bridge_strap = 1'h0, hotplug_strap = 1'h0;
  logic        slot_ident_enable = 1'h0, power_limit_msg = 1'h0, reverse_mode;
  logic [7:0]  power_limit_value = '0, captured_power_value;
  logic [1:0]  power_limit_scale = '0, captured_power_scale;
  logic        m_rev, m_hp, m_sie = 1'h0;
  logic [7:0]  m_pv;
  logic [1:0]  m_ps;
  int          fails = 0;
  int          n_compared = 0;

  bccs_config_space dut (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .reverse_bridge_strap(reverse_bridge_strap), .hotplug_strap(hotplug_strap),
    .slot_ident_enable(slot_ident_enable), .power_limit_msg(power_limit_msg),
    .power_limit_value(power_limit_value), .power_limit_scale(power_limit_scale),
    .captured_power_value(captured_power_value), .captured_power_scale(captured_power_scale),
    .reverse_mode(reverse_mode)
  );

  always #12.5 clk_sys = ~clk_sys;

  // ********************
  // expectations and bus tasks
  // ********************
  function automatic logic [31:0] exp_word(input logic [7:0] a);
    case (a)
      8'hA8: exp_word = {16'h0000, (m_sie ? 8'hA0 : 8'hB0), 8'h0D};
      8'hAC: exp_word = {BCCS_CARD_IDENT_DEF, BCCS_CARD_MAKER_DEF};
      8'hB0: exp_word = {7'h00, m_rev, (m_rev ? 4'h8 : 4'h7), 4'h1, 16'hD810};
      8'hB4: exp_word = {4'h0, m_ps, m_pv, 3'h0, {3{m_hp & ~m_rev}}, 6'h00, 1'h1, 5'h01};
      default: exp_word = 32'h0000_0000;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      $display("MISMATCH %s expected %h seen %h", what, expv, seen);
      fails++;
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready === 1'h1) begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'h1) begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  // straps are flipped after release to show that only the reset value counts
  task automatic do_reset(input logic rev, input logic hp);
    rst <= 1'h1;
    reverse_bridge_strap <= rev;
    hotplug_strap <= hp;
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    m_rev = rev;
    m_hp = hp;
    m_pv = '0;
    m_ps = '0;
    @(posedge clk_sys);
    reverse_bridge_strap <= ~rev;
    hotplug_strap <= ~hp;
    @(posedge clk_sys);
    check("reverse_mode", {31'h0, reverse_mode}, {31'h0, rev});
  endtask

  task automatic check_all();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(BCCS_OFS_SUBSYS_HDR, d, r);
    check("subsys header", d, exp_word(8'hA8));
    axi_read(BCCS_OFS_CARD_IDENT, d, r);
    check("card ident", d, exp_word(8'hAC));
    axi_read(BCCS_OFS_EXPRESS_HDR, d, r);
    check("express header", d, exp_word(8'hB0));
    axi_read(BCCS_OFS_DEVCAP, d, r);
    check("device capability", d, exp_word(8'hB4));
    check("rresp", {30'h0, r}, 32'h0);
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1], i[0]);
      check_all();
    end
  endtask

  task automatic t_slot_ident();
    logic [31:0] d;
    logic [1:0]  r;
    for (int j = 1; j >= 0; j--) begin
      @(posedge clk_sys);
      slot_ident_enable <= j[0];
      m_sie = j[0];
      axi_read(BCCS_OFS_SUBSYS_HDR, d, r);
      check("next link", d, exp_word(8'hA8));
    end
  endtask

  task automatic t_write_ignored();
    logic [7:0]  adr [6] = '{8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'h00, 8'hFC};
    logic [31:0] d;
    logic [1:0]  r;
    foreach (adr[k]) begin
      axi_write(adr[k], 32'hFFFF_FFFF, r);
      check("bresp", {30'h0, r}, {30'h0, (k < 4) ? BCCS_RESP_OKAY : BCCS_RESP_SLVERR});
      axi_read(adr[k], d, r);
      check("read after write", d, exp_word(adr[k]));
      check("rresp", {30'h0, r}, {30'h0, (k < 4) ? BCCS_RESP_OKAY : BCCS_RESP_SLVERR});
    end
  endtask

  // two messages back to back: the later one must win
  task automatic t_power();
    @(posedge clk_sys);
    power_limit_msg <= 1'h1;
    power_limit_value <= 8'hFF;
    power_limit_scale <= 2'h3;
    @(posedge clk_sys);
    power_limit_value <= 8'hA7;
    power_limit_scale <= 2'h1;
    @(posedge clk_sys);
    power_limit_msg <= 1'h0;
    m_pv = 8'hA7;
    m_ps = 2'h1;
    repeat (2) @(posedge clk_sys);
    check("captured power", {22'h0, captured_power_scale, captured_power_value},
          {22'h0, m_ps, m_pv});
    check_all();
    do_reset(1'h0, 1'h1);
    check_all();
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    t_modes();
    t_slot_ident();
    t_write_ignored();
    t_power();
    close_out();
  end

  // the full run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    close_out();
  end
endmodule // bccs_config_space_tb
